// ===== core/tosc_chan_counter.sv
/*
 Down counter of one timer channel, reloading from its period.
 Assumes the parent holds count_en_i high while the channel runs.
*/
module tosc_chan_counter
    import tosc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        count_en_i,
    input  wire logic        restart_i,
    input  wire logic [15:0] period_i,
    output logic             tc_o,
    output logic [15:0]      count_o
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tc;
    } tosc_cnt_state_t;

    tosc_cnt_state_t s_r;
    tosc_cnt_state_t s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.tc = 1'b0;
        if (restart_i || !count_en_i) begin
            s_nxt.cnt = period_i;
        end else if (s_r.cnt == 16'h0000) begin
            s_nxt.cnt = period_i;
            s_nxt.tc  = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r     <= '0;
            s_r.cnt <= RST_PERIOD;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tc_o    = s_r.tc;
    assign count_o = s_r.cnt;

endmodule : tosc_chan_counter

// ===== core/tosc_pkg.sv
/*
 Constants for the timer output and start control block.
 Assumes one 40 MHz clock, a synchronous active high reset and a word-aligned Avalon-MM slave.
*/
// How it works
// - Bit 1 of the 8-bit pin latch sets the pin level: 0 drives low, 1 drives high.
// - Pin direction bit 0 turns the output buffer on and 1 turns it off.
// - With its output enable clear, a channel output bit takes software writes as the pin level.
// - With its output enable set, the timer toggles the output bit and software writes are ignored.
// - The output enable register is 32 bits, with channel enables in bits 3..0 and zeros above.
// - Writing 1 to start bit 3 sets channel 3 enabled; writing 0 there does nothing.
// - Writing 1 to start bit 0 sets channel 0 enabled; writing 0 there does nothing.
// - An enabled channel starts counting at once or on its trigger input, as its mode selects.
// - The start register holds channel starts in bits 3..0 and high half starts in bits 9 and 11.
// - A channel output bit shows the present output value, 0 low and 1 high.
// - A polarity bit of 0 gives active high output and 1 gives active low output.
package tosc_pkg;

    localparam int         NUM_CH       = 4;
    localparam int         CH0          = 0;
    localparam int         CH3          = 3;
    localparam int         PIN1_BIT     = 1;
    localparam int         HH_CH1_BIT   = 9;
    localparam int         HH_CH3_BIT   = 11;

    localparam logic [5:0] OFS_LATCH    = 6'h00;
    localparam logic [5:0] OFS_DIR      = 6'h04;
    localparam logic [5:0] OFS_OE       = 6'h08;
    localparam logic [5:0] OFS_POL      = 6'h0C;
    localparam logic [5:0] OFS_TOV      = 6'h10;
    localparam logic [5:0] OFS_START    = 6'h14;
    localparam logic [5:0] OFS_STOP     = 6'h18;
    localparam logic [5:0] OFS_STATUS   = 6'h1C;
    localparam logic [5:0] OFS_MODE     = 6'h20;
    localparam logic [5:0] OFS_PIN_IN   = 6'h24;
    localparam logic [5:0] OFS_PERIOD0  = 6'h30;
    localparam logic [5:0] PERIOD_STEP  = 6'h04;

    localparam logic [7:0]  RST_LATCH   = 8'h00;
    localparam logic [7:0]  RST_DIR     = 8'hFF;
    localparam logic [3:0]  RST_OE      = 4'h0;
    localparam logic [3:0]  RST_POL     = 4'h0;
    localparam logic [3:0]  RST_TOV     = 4'h0;
    localparam logic [3:0]  RST_MODE    = 4'h0;
    localparam logic [15:0] RST_PERIOD  = 16'h00FF;

endpackage : tosc_pkg

// ===== core/tosc_top.sv
/*
 Pin latch, pin direction, timer output enable, polarity and channel start control.
 Assumes an Avalon-MM master holding each request until waitrequest is low.
*/
module tosc_top
    import tosc_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    input  wire logic [5:0]  ADDRESS_I,
    input  wire logic        READ_I,
    input  wire logic        WRITE_I,
    input  wire logic [31:0] WRITEDATA_I,
    input  wire logic [3:0]  BYTEENABLE_I,
    output logic      [31:0] READDATA_O,
    output logic             WAITREQUEST_O,
    input  wire logic [7:0]  PIN_I,
    output logic      [7:0]  PIN_O,
    output logic      [7:0]  PIN_OE_O,
    input  wire logic [3:0]  TRIG_I,
    output logic      [3:0]  TMR_O,
    output logic      [3:0]  CH_ENABLED_O,
    output logic      [3:0]  CH_COUNTING_O
);

    typedef struct packed {
        logic             ack;
        logic [31:0]      rdata;
        logic [7:0]       latch;
        logic [7:0]       dir;
        logic [7:0]       pin_oe;
        logic [3:0]       oe;
        logic [3:0]       pol;
        logic [3:0]       tov;
        logic [3:0]       tmr;
        logic [3:0]       te;
        logic [1:0]       hh;
        logic [3:0]       mode;
        logic [3:0]       run;
        logic [3:0]       trig_s1;
        logic [3:0]       trig_s2;
        logic [3:0]       trig_d;
        logic [7:0]       pin_s1;
        logic [7:0]       pin_s2;
        logic [3:0][15:0] period;
    } tosc_state_t;

    tosc_state_t s_r;
    tosc_state_t s_nxt;

    logic [3:0]  tc;
    logic [5:0]  word_addr;
    logic        wr_acc;
    logic        rd_first;
    logic [3:0]  start_v;
    logic [3:0]  stop_v;
    logic [3:0]  restart;
    logic [31:0] rd_val;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] d,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? d[15:8] : old_v[15:8], be[0] ? d[7:0] : old_v[7:0]};
    endfunction : merge16

    function automatic logic [5:0] period_ofs(input int c);
        period_ofs = OFS_PERIOD0 + 6'(c) * PERIOD_STEP;
    endfunction : period_ofs

    assign word_addr     = {ADDRESS_I[5:2], 2'b00};
    assign WAITREQUEST_O = (READ_I || WRITE_I) && !s_r.ack;
    assign wr_acc        = WRITE_I && s_r.ack;
    assign rd_first      = READ_I && !s_r.ack;

    // Start and stop strobes live for one cycle only
    assign start_v = (wr_acc && word_addr == OFS_START && BYTEENABLE_I[0])
                     ? WRITEDATA_I[3:0] : 4'h0;
    assign stop_v  = (wr_acc && word_addr == OFS_STOP && BYTEENABLE_I[0])
                     ? WRITEDATA_I[3:0] : 4'h0;
    assign restart = start_v;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tosc_chan_counter u_cnt (
                .clk_i      (CLOCK_I),
                .rst_i      (RST_I),
                .count_en_i (s_r.run[g]),
                .restart_i  (restart[g]),
                .period_i   (s_r.period[g]),
                .tc_o       (tc[g]),
                .count_o    ()
            );
        end
    endgenerate

    // Read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (word_addr)
            OFS_LATCH:  rd_val = {24'h00_0000, s_r.latch};
            OFS_DIR:    rd_val = {24'h00_0000, s_r.dir};
            OFS_OE:     rd_val = {28'h000_0000, s_r.oe};
            OFS_POL:    rd_val = {28'h000_0000, s_r.pol};
            OFS_TOV:    rd_val = {28'h000_0000, s_r.tov};
            OFS_START:  rd_val = 32'h0000_0000;
            OFS_STATUS: rd_val = {20'h0_0000, s_r.hh[1], 1'b0, s_r.hh[0], 1'b0,
                                  s_r.run, s_r.te};
            OFS_MODE:   rd_val = {28'h000_0000, s_r.mode};
            OFS_PIN_IN: rd_val = {24'h00_0000, s_r.pin_s2};
            default: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (word_addr == period_ofs(c)) begin
                        rd_val = {16'h0000, s_r.period[c]};
                    end
                end
            end
        endcase
    end

    always_comb begin
        s_nxt         = s_r;
        s_nxt.ack     = (READ_I || WRITE_I) && !s_r.ack;
        s_nxt.rdata   = rd_first ? rd_val : s_r.rdata;
        s_nxt.trig_s1 = TRIG_I;
        s_nxt.trig_s2 = s_r.trig_s1;
        s_nxt.trig_d  = s_r.trig_s2;
        s_nxt.pin_s1  = PIN_I;
        s_nxt.pin_s2  = s_r.pin_s1;

        if (wr_acc && BYTEENABLE_I[0]) begin
            if (word_addr == OFS_LATCH) begin
                s_nxt.latch = WRITEDATA_I[7:0];
            end
            if (word_addr == OFS_DIR) begin
                s_nxt.dir = WRITEDATA_I[7:0];
            end
            if (word_addr == OFS_OE) begin
                s_nxt.oe = WRITEDATA_I[3:0];
            end
            if (word_addr == OFS_POL) begin
                s_nxt.pol = WRITEDATA_I[3:0];
            end
            if (word_addr == OFS_MODE) begin
                s_nxt.mode = WRITEDATA_I[3:0];
            end
        end
        for (int c = 0; c < NUM_CH; c++) begin
            if (wr_acc && word_addr == period_ofs(c)) begin
                s_nxt.period[c] = merge16(s_r.period[c], WRITEDATA_I, BYTEENABLE_I);
            end
        end

        for (int c = 0; c < NUM_CH; c++) begin
            // Start wins over a stop in the same cycle
            s_nxt.te[c]  = (s_r.te[c] && !stop_v[c]) || start_v[c];
            s_nxt.run[c] = s_nxt.te[c] &&
                           (s_r.run[c] ||
                            (start_v[c] && !s_r.mode[c]) ||
                            (s_r.mode[c] && s_r.trig_s2[c] && !s_r.trig_d[c]));
            if (s_r.oe[c]) begin
                if (tc[c] && s_r.run[c]) begin
                    s_nxt.tov[c] = !s_r.tov[c];
                end
            end else if (wr_acc && word_addr == OFS_TOV && BYTEENABLE_I[0]) begin
                s_nxt.tov[c] = WRITEDATA_I[c];
            end
        end

        // High half starts for channels 1 and 3
        if (wr_acc && word_addr == OFS_START && BYTEENABLE_I[1]) begin
            s_nxt.hh[0] = s_r.hh[0] || WRITEDATA_I[HH_CH1_BIT];
            s_nxt.hh[1] = s_r.hh[1] || WRITEDATA_I[HH_CH3_BIT];
        end
        if (wr_acc && word_addr == OFS_STOP && BYTEENABLE_I[1]) begin
            s_nxt.hh[0] = s_r.hh[0] && !WRITEDATA_I[HH_CH1_BIT];
            s_nxt.hh[1] = s_r.hh[1] && !WRITEDATA_I[HH_CH3_BIT];
        end

        s_nxt.tmr    = s_nxt.tov ^ s_nxt.pol;
        s_nxt.pin_oe = ~s_nxt.dir;
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            s_r        <= '0;
            s_r.latch  <= RST_LATCH;
            s_r.dir    <= RST_DIR;
            s_r.pin_oe <= ~RST_DIR;
            s_r.oe     <= RST_OE;
            s_r.pol    <= RST_POL;
            s_r.tov    <= RST_TOV;
            s_r.tmr    <= RST_TOV ^ RST_POL;
            s_r.mode   <= RST_MODE;
            s_r.period <= {NUM_CH{RST_PERIOD}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign READDATA_O    = s_r.rdata;
    assign PIN_O         = s_r.latch;
    assign PIN_OE_O      = s_r.pin_oe;
    assign TMR_O         = s_r.tmr;
    assign CH_ENABLED_O  = s_r.te;
    assign CH_COUNTING_O = s_r.run;

    // Checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RST_I);

    a_latch_pin_level: assert property (
        (wr_acc && word_addr == OFS_LATCH && BYTEENABLE_I[0])
        |=> PIN_O[PIN1_BIT] == $past(WRITEDATA_I[PIN1_BIT]))
        else $error("Pin latch bit 1 not driven as written");

    a_dir_buffer: assert property (
        (wr_acc && word_addr == OFS_DIR && BYTEENABLE_I[0])
        |=> PIN_OE_O[PIN1_BIT] == !$past(WRITEDATA_I[PIN1_BIT]))
        else $error("Pin buffer enable does not follow direction bit");

    a_tov_write_ok: assert property (
        (wr_acc && word_addr == OFS_TOV && BYTEENABLE_I[0] && !s_r.oe[CH0])
        |=> s_r.tov[CH0] == $past(WRITEDATA_I[CH0]))
        else $error("Output bit write lost while timer output off");

    a_tov_write_ign: assert property (
        (s_r.oe[CH3] && !(tc[CH3] && s_r.run[CH3]))
        |=> $stable(s_r.tov[CH3]))
        else $error("Output bit changed without timer event");

    a_oe_upper_zero: assert property (
        (READ_I && !WAITREQUEST_O && word_addr == OFS_OE) |-> READDATA_O[31:4] == 28'h000_0000)
        else $error("Output enable upper bits not zero");

    a_start_ch3: assert property (
        (wr_acc && word_addr == OFS_START && BYTEENABLE_I[0] && WRITEDATA_I[CH3])
        |=> CH_ENABLED_O[CH3] ##1 CH_ENABLED_O[CH3] || $past(stop_v[CH3]))
        else $error("Channel 3 not enabled by start");

    a_start_ch0: assert property (
        (wr_acc && word_addr == OFS_START && BYTEENABLE_I[0] && WRITEDATA_I[CH0])
        |=> CH_ENABLED_O[CH0])
        else $error("Channel 0 not enabled by start");

    a_start_zero_noop: assert property (
        (!CH_ENABLED_O[CH0] && !(wr_acc && word_addr == OFS_START && WRITEDATA_I[CH0]))
        |=> !CH_ENABLED_O[CH0])
        else $error("Channel 0 enabled without start");

    a_mode_immediate: assert property (
        (start_v[CH0] && !s_r.mode[CH0] && !stop_v[CH0]) |=> CH_COUNTING_O[CH0])
        else $error("Immediate mode channel did not start counting");

    a_mode_wait_trig: assert property (
        (!s_r.run[CH3] && s_r.mode[CH3] && !(s_r.trig_s2[CH3] && !s_r.trig_d[CH3]))
        |=> !CH_COUNTING_O[CH3])
        else $error("Trigger mode channel counted without trigger");

    a_high_half: assert property (
        (wr_acc && word_addr == OFS_START && BYTEENABLE_I[1] && WRITEDATA_I[HH_CH3_BIT])
        |=> s_r.hh[1])
        else $error("Channel 3 high half not started");

    a_polarity_out: assert property (
        ##1 TMR_O == (s_r.tov ^ s_r.pol))
        else $error("Timer output polarity wrong");

    a_start_reads_zero: assert property (
        (READ_I && !WAITREQUEST_O && word_addr == OFS_START) |-> READDATA_O == 32'h0000_0000)
        else $error("Start register read not zero");

    a_wait_one: assert property (
        $rose(READ_I) |-> WAITREQUEST_O ##1 !WAITREQUEST_O)
        else $error("Read not answered after one wait state");

    a_tov_timer_flip: assert property (
        (s_r.oe[CH0] && tc[CH0] && s_r.run[CH0])
        |=> s_r.tov[CH0] != $past(s_r.tov[CH0]))
        else $error("Output bit did not toggle on timer event");

    a_tov_write_block: assert property (
        (wr_acc && word_addr == OFS_TOV && BYTEENABLE_I[0] && s_r.oe[CH0] && !tc[CH0])
        |=> $stable(s_r.tov[CH0]))
        else $error("Output bit took a write while timer output on");

    a_tov_fixed_off: assert property (
        (!s_r.oe[CH3] && !(wr_acc && word_addr == OFS_TOV && BYTEENABLE_I[0]))
        |=> $stable(s_r.tov[CH3]))
        else $error("Output bit moved while timer output off");

    a_start_one_pulse: assert property (
        (wr_acc && word_addr == OFS_START) |=> start_v == 4'h0)
        else $error("Start strobe lasted more than one cycle");

    a_wait_write: assert property (
        $rose(WRITE_I) |-> WAITREQUEST_O ##1 !WAITREQUEST_O)
        else $error("Write not answered after one wait state");

    c_both_start: cover property (start_v[CH0] && start_v[CH3]);
    c_trig_start: cover property (s_r.mode[CH3] && $rose(CH_COUNTING_O[CH3]));
    c_timer_toggle: cover property (s_r.oe[CH0] && $changed(s_r.tov[CH0]));
    c_ignored_write: cover property (wr_acc && word_addr == OFS_TOV && s_r.oe[CH3]);

endmodule : tosc_top

// ===== tb/tosc_bench.sv
/*
 Self-checking bench for tosc_top: registers over Avalon-MM, pin, timer output and start.
 Assumes the register map, reset values and single wait state of the design package.
*/
module tosc_bench
    import tosc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst;
    logic [5:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [7:0]  pin_in;
    logic [3:0]  trig;
    logic [31:0] rdata;
    logic        wait_req;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe;
    logic [3:0]  tmr;
    logic [3:0]  ch_en;
    logic [3:0]  ch_cnt;
    int          n_fail = 0;
    int          n_checks = 0;
    int          i;
    int          n;
    logic        last;

    always #12.5 clk = ~clk;

    tosc_top i_dut (
        .CLOCK_I       (clk),
        .RST_I         (rst),
        .ADDRESS_I     (addr),
        .READ_I        (rd),
        .WRITE_I       (wr),
        .WRITEDATA_I   (wdata),
        .BYTEENABLE_I  (be),
        .READDATA_O    (rdata),
        .WAITREQUEST_O (wait_req),
        .PIN_I         (pin_in),
        .PIN_O         (pin_o),
        .PIN_OE_O      (pin_oe),
        .TRIG_I        (trig),
        .TMR_O         (tmr),
        .CH_ENABLED_O  (ch_en),
        .CH_COUNTING_O (ch_cnt)
    );

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic timeout(input string what);
        n_fail++;
        $display("[ERR] %0t wait for %s ran out", $time, what);
        results();
    endtask : timeout

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        rd    <= ~w;
        wr    <= w;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (wait_req === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k == 20) timeout("waitrequest");
    endtask : bus

    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        @(negedge clk);
    endtask : wr_reg

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask : rd_chk

    initial begin
        rst    = 1'b1;
        rd     = 1'b0;
        wr     = 1'b0;
        addr   = 6'h00;
        wdata  = 32'h0;
        be     = 4'hF;
        pin_in = 8'h5A;
        trig   = 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;

        rd_chk(OFS_LATCH, {24'h0, RST_LATCH}, "latch reset");
        rd_chk(OFS_DIR, {24'h0, RST_DIR}, "direction reset");
        rd_chk(OFS_OE, {28'h0, RST_OE}, "enable reset");
        chk({24'h0, pin_oe}, 32'h0, "pin drive reset");
        rd_chk(OFS_PIN_IN, 32'h5A, "pin input");
        wr_reg(6'h28, 32'hFFFF_FFFF);
        rd_chk(6'h28, 32'h0, "unmapped");
        $display("test reset done");

        wr_reg(OFS_LATCH, 32'h02);
        chk({24'h0, pin_o}, 32'h02, "pin high");
        wr_reg(OFS_LATCH, 32'h00);
        chk({24'h0, pin_o}, 32'h00, "pin low");
        wr_reg(OFS_DIR, 32'hFD);
        chk({24'h0, pin_oe}, 32'h02, "buffer on");
        wr_reg(OFS_DIR, 32'hFF);
        chk({24'h0, pin_oe}, 32'h00, "buffer off");
        $display("test pin done");

        wr_reg(OFS_OE, 32'hFFFF);
        rd_chk(OFS_OE, 32'h0F, "enable width");
        wr_reg(OFS_OE, 32'h0);
        rd_chk(OFS_OE, 32'h0, "enable clear");
        wr_reg(OFS_TOV, 32'h9);
        rd_chk(OFS_TOV, 32'h9, "value write");
        chk({28'h0, tmr}, 32'h9, "timer out");
        wr_reg(OFS_POL, 32'h8);
        chk({28'h0, tmr}, 32'h1, "active low");
        rd_chk(OFS_TOV, 32'h9, "value kept");
        wr_reg(OFS_POL, 32'h0);
        wr_reg(OFS_OE, 32'h9);
        wr_reg(OFS_TOV, 32'h6);
        rd_chk(OFS_TOV, 32'hF, "masked write");
        $display("test output done");

        wr_reg(OFS_START, 32'h0);
        chk({28'h0, ch_en}, 32'h0, "zero start");
        wr_reg(OFS_PERIOD0, 32'h3);
        wr_reg(OFS_START, 32'h9);
        chk({28'h0, ch_en}, 32'h9, "both enabled");
        chk({28'h0, ch_cnt}, 32'h9, "both counting");
        rd_chk(OFS_START, 32'h0, "start reads 0");
        rd_chk(OFS_STATUS, 32'h99, "status");
        wr_reg(OFS_START, 32'hA00);
        rd_chk(OFS_STATUS, 32'hA99, "high half");
        last = tmr[0];
        for (i = 0; i < 20 && tmr[0] === last; i++) @(negedge clk);
        if (i == 20) timeout("first toggle");
        last = tmr[0];
        for (n = 0; n < 20 && tmr[0] === last; n++) @(negedge clk);
        chk(n, 32'd4, "toggle spacing");
        $display("test start done");

        wr_reg(OFS_STOP, 32'h8);
        wr_reg(OFS_MODE, 32'h8);
        wr_reg(OFS_START, 32'h8);
        chk({31'h0, ch_en[3]}, 32'h1, "mode 1 enabled");
        repeat (5) @(negedge clk);
        chk({31'h0, ch_cnt[3]}, 32'h0, "mode 1 waits");
        @(posedge clk);
        trig <= 4'h8;
        for (i = 0; i < 8 && ch_cnt[3] !== 1'b1; i++) @(negedge clk);
        chk({31'h0, ch_cnt[3]}, 32'h1, "mode 1 runs");
        $display("test mode done");
        results();
    end
endmodule : tosc_bench
